// [efp_ethernet_frame_and_pause_generation.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] Seven 0x55 preamble octets start frames
// [R2] One 0xD5 delimiter follows the preamble
// [R3] Six-octet addresses sent low byte first
// [R4] Length/type 1536 or above is EtherType
// [R5] Length/type sent high byte first
// [R6] Four-octet CRC ends every frame
// [R7] No carrier extension is ever generated
// [R8] Payload up to 1500/9600, short ones padded
// [R9] VLAN tag is 0x8100 plus info
// [R10] VLAN frames up to 1522 bytes accepted
// [R11] Stacked VLAN carries two consecutive tags
// [R12] Stop data toward paused remote station
// [R13] Pause frame type 0x8808, opcode 0x0001
// [R14] Quanta in payload bytes two, three
// [R15] Pause frame padded with 42 zeros
// [R16] Threshold, bits or pins trigger pause
// [R17] Software sets larger threshold with requests
// [R18] XOFF alone repeats XOFF pause frames
// [R19] XON alone repeats XON pause frames
// [R20] Never request XOFF and XON together
// [R21] Use bits or pins, not both
// [R22] XOFF carries quanta, XON carries zero
// [R23] CRC-32 over addresses through pad
module efp_ethernet_frame_and_pause_generation (
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic             fc_enable,
   input  wire logic             rx_fifo_at_threshold,
   input  wire logic             xoff_req_bit,
   input  wire logic             xon_req_bit,
   input  wire logic             xoff_pin,
   input  wire logic             xon_pin,
   input  wire logic [15:0]      pause_quanta,
   input  wire logic [47:0]      station_addr,
   input  wire logic [47:0]      pause_dst_addr,
   input  wire logic             remote_paused,
   input  wire logic             tx_start,
   input  wire efp_pkg::efp_hdr_s tx_hdr,
   input  wire logic [7:0]       tx_data,
   input  wire logic             tx_last,
   output logic                  tx_data_ready,
   output logic                  tx_busy,
   output logic                  tx_len_error,
   output logic                  is_ethertype,
   output efp_pkg::efp_tx_s      mii_tx
);

   // ******************************************************
   // Helpers
   // ******************************************************
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ efp_pkg::CRC_POLY_R) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [3:0] i);
      return a[8*i +: 8];
   endfunction

   // ******************************************************
   // Frame state
   // ******************************************************
   efp_pkg::efp_state_e st_q, st_d;
   efp_pkg::efp_kind_e  kind_q, kind_d;
   efp_pkg::efp_hdr_s   hdr_q, hdr_d;
   logic [13:0] cnt_q, cnt_d;
   logic [13:0] body_q, body_d;
   logic [31:0] crc_q, crc_d;
   logic [15:0] quanta_q, quanta_d;
   logic        thr_pend_q, thr_pend_d;
   logic        thr_prev_q, thr_prev_d;
   logic        rdy_q, rdy_d;
   logic        busy_q, busy_d;
   logic        lerr_q, lerr_d;
   logic        etype_q, etype_d;
   efp_pkg::efp_tx_s out_q, out_d;

   logic        xoff_act, xon_act, pause_xoff, pause_xon, pause_go;
   logic [7:0]  byte_v;
   logic        byte_en, crc_on;
   logic [15:0] lt_v;
   logic [13:0] max_pay;
   logic [13:0] min_body;

   always_comb begin
      // [R16] Pause trigger sources
      xoff_act   = fc_enable & (xoff_req_bit | xoff_pin);
      xon_act    = fc_enable & (xon_req_bit | xon_pin);
      // [R18] XOFF repeats alone
      pause_xoff = xoff_act & ~xon_act;
      // [R19] XON repeats alone
      pause_xon  = xon_act & ~xoff_act;
      pause_go   = pause_xoff | pause_xon | thr_pend_q;
   end

   always_comb begin
      st_d     = st_q;
      kind_d   = kind_q;
      hdr_d    = hdr_q;
      cnt_d    = cnt_q;
      body_d   = body_q;
      crc_d    = crc_q;
      quanta_d = quanta_q;
      rdy_d    = 1'b0;
      busy_d   = (st_q != efp_pkg::EFP_IDLE);
      lerr_d   = lerr_q;
      etype_d  = etype_q;
      thr_prev_d = rx_fifo_at_threshold;
      thr_pend_d = thr_pend_q | (fc_enable & rx_fifo_at_threshold & ~thr_prev_q);
      byte_v   = 8'h00;
      byte_en  = 1'b1;
      crc_on   = 1'b0;
      lt_v     = (kind_q == efp_pkg::EFP_K_DATA) ? hdr_q.len_type : efp_pkg::PAUSE_TYPE;
      max_pay  = hdr_q.jumbo_en ? efp_pkg::MAX_PAYLOAD_JMB : efp_pkg::MAX_PAYLOAD_STD;
      // VLAN tags count toward the minimum body
      min_body = 14'(efp_pkg::MIN_BODY_LEN) - {10'h000, hdr_q.vlan_count, 2'b00};
      case (st_q)
         efp_pkg::EFP_IDLE: begin
            byte_en = 1'b0;
            cnt_d   = '0;
            body_d  = '0;
            crc_d   = efp_pkg::CRC_INIT;
            if (pause_go) begin
               kind_d     = pause_xon ? efp_pkg::EFP_K_XON : efp_pkg::EFP_K_XOFF;
               // [R22] Quanta per pause kind
               quanta_d   = pause_xon ? efp_pkg::QUANTA_ZERO : pause_quanta;
               hdr_d.dst_addr   = pause_dst_addr;
               hdr_d.src_addr   = station_addr;
               hdr_d.vlan_count = 2'b00;
               // New threshold edge in the same cycle stays queued
               thr_pend_d = fc_enable & rx_fifo_at_threshold & ~thr_prev_q;
               st_d       = efp_pkg::EFP_PRE;
            // [R12] Hold data while paused
            end else if (tx_start && !remote_paused) begin
               kind_d = efp_pkg::EFP_K_DATA;
               hdr_d  = tx_hdr;
               lerr_d = 1'b0;
               // [R4] EtherType threshold
               etype_d = (tx_hdr.len_type >= efp_pkg::ETYPE_MIN);
               st_d   = efp_pkg::EFP_PRE;
            end
         end
         efp_pkg::EFP_PRE: begin
            // [R1] Preamble octets
            byte_v = efp_pkg::PREAMBLE_BYTE;
            cnt_d  = cnt_q + 14'h0001;
            if (cnt_q[3:0] == efp_pkg::PREAMBLE_LEN - 4'h1) begin
               cnt_d = '0;
               st_d  = efp_pkg::EFP_SFD;
            end
         end
         efp_pkg::EFP_SFD: begin
            // [R2] Start delimiter
            byte_v = efp_pkg::SFD_BYTE;
            st_d   = efp_pkg::EFP_DA;
         end
         efp_pkg::EFP_DA, efp_pkg::EFP_SA: begin
            // [R3] Low address byte first
            byte_v = addr_byte((st_q == efp_pkg::EFP_DA) ? hdr_q.dst_addr : hdr_q.src_addr, cnt_q[3:0]);
            crc_on = 1'b1;
            cnt_d  = cnt_q + 14'h0001;
            if (cnt_q == 14'h0005) begin
               cnt_d = '0;
               if (st_q == efp_pkg::EFP_DA)
                  st_d = efp_pkg::EFP_SA;
               else
                  st_d = (hdr_q.vlan_count != 2'b00) ? efp_pkg::EFP_VLAN : efp_pkg::EFP_LT;
            end
         end
         efp_pkg::EFP_VLAN: begin
            // [R9] [R11] Tag 0x8100 then info, once or twice
            case (cnt_q[1:0])
               2'b00:   byte_v = efp_pkg::VLAN_TPID[15:8];
               2'b01:   byte_v = efp_pkg::VLAN_TPID[7:0];
               2'b10:   byte_v = cnt_q[2] ? hdr_q.vlan_tags[15:8] : hdr_q.vlan_tags[31:24];
               default: byte_v = cnt_q[2] ? hdr_q.vlan_tags[7:0] : hdr_q.vlan_tags[23:16];
            endcase
            crc_on = 1'b1;
            cnt_d  = cnt_q + 14'h0001;
            if (cnt_q[1:0] == 2'b11 && (cnt_q[2] || hdr_q.vlan_count == 2'b01)) begin
               cnt_d = '0;
               st_d  = efp_pkg::EFP_LT;
            end
         end
         efp_pkg::EFP_LT: begin
            // [R5] [R13] Type high byte first
            byte_v = cnt_q[0] ? lt_v[7:0] : lt_v[15:8];
            crc_on = 1'b1;
            cnt_d  = cnt_q + 14'h0001;
            if (cnt_q[0]) begin
               cnt_d = '0;
               st_d  = efp_pkg::EFP_PAYLD;
               rdy_d = (kind_q == efp_pkg::EFP_K_DATA);
            end
         end
         efp_pkg::EFP_PAYLD: begin
            crc_on = 1'b1;
            body_d = body_q + 14'h0001;
            if (kind_q != efp_pkg::EFP_K_DATA) begin
               // [R13] [R14] Opcode, then quanta high then low
               case (body_q[1:0])
                  2'b00:   byte_v = efp_pkg::PAUSE_OPCODE[15:8];
                  2'b01:   byte_v = efp_pkg::PAUSE_OPCODE[7:0];
                  2'b10:   byte_v = quanta_q[15:8];
                  default: byte_v = quanta_q[7:0];
               endcase
               if (body_q[1:0] == 2'b11)
                  st_d = efp_pkg::EFP_PAD;
            end else begin
               byte_v = tx_data;
               rdy_d  = !tx_last;
               // [R8] [R10] Payload limit
               if (body_q >= max_pay)
                  lerr_d = 1'b1;
               if (tx_last)
                  st_d = (body_q + 14'h0001 < min_body) ? efp_pkg::EFP_PAD : efp_pkg::EFP_FCS;
            end
         end
         efp_pkg::EFP_PAD: begin
            // [R8] [R15] Zero pad up to minimum body
            byte_v = 8'h00;
            crc_on = 1'b1;
            body_d = body_q + 14'h0001;
            if (body_q + 14'h0001 >= min_body)
               st_d = efp_pkg::EFP_FCS;
         end
         efp_pkg::EFP_FCS: begin
            // [R6] [R23] Inverted CRC, low byte first
            byte_v = ~crc_q[8*cnt_q[1:0] +: 8];
            cnt_d  = cnt_q + 14'h0001;
            if (cnt_q[1:0] == 2'b11) begin
               // [R7] Frame ends, no extension
               cnt_d = '0;
               st_d  = efp_pkg::EFP_IDLE;
            end
         end
         default: begin
            byte_en = 1'b0;
            st_d    = efp_pkg::EFP_IDLE;
         end
      endcase
      if (crc_on)
         crc_d = crc_byte(crc_q, byte_v);
      out_d.data = byte_en ? byte_v : 8'h00;
      out_d.en   = byte_en;
   end

   // ******************************************************
   // Registers
   // ******************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q       <= efp_pkg::EFP_IDLE;
         kind_q     <= efp_pkg::EFP_K_DATA;
         hdr_q      <= '0;
         cnt_q      <= '0;
         body_q     <= '0;
         crc_q      <= efp_pkg::CRC_INIT;
         quanta_q   <= '0;
         thr_pend_q <= 1'b0;
         thr_prev_q <= 1'b0;
         rdy_q      <= 1'b0;
         busy_q     <= 1'b0;
         lerr_q     <= 1'b0;
         etype_q    <= 1'b0;
         out_q      <= '0;
      end else begin
         st_q       <= st_d;
         kind_q     <= kind_d;
         hdr_q      <= hdr_d;
         cnt_q      <= cnt_d;
         body_q     <= body_d;
         crc_q      <= crc_d;
         quanta_q   <= quanta_d;
         thr_pend_q <= thr_pend_d;
         thr_prev_q <= thr_prev_d;
         rdy_q      <= rdy_d;
         busy_q     <= busy_d;
         lerr_q     <= lerr_d;
         etype_q    <= etype_d;
         out_q      <= out_d;
      end
   end

   // ******************************************************
   // Outputs
   // ******************************************************
   assign tx_data_ready = rdy_q;
   assign tx_busy       = busy_q;
   assign tx_len_error  = lerr_q;
   assign is_ethertype  = etype_q;
   assign mii_tx        = out_q;

endmodule
`default_nettype wire

// [efp_pkg.sv]
`default_nettype none
package efp_pkg;
   localparam logic [7:0]  PREAMBLE_BYTE   = 8'h55;
   localparam logic [7:0]  SFD_BYTE        = 8'hD5;
   localparam logic [3:0]  PREAMBLE_LEN    = 4'h7;
   localparam logic [15:0] VLAN_TPID       = 16'h8100;
   localparam logic [15:0] PAUSE_TYPE      = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE    = 16'h0001;
   localparam logic [15:0] ETYPE_MIN       = 16'h0600;
   localparam logic [5:0]  PAUSE_PAD_LEN   = 6'h2A;
   localparam logic [5:0]  MIN_BODY_LEN    = 6'h2E;
   localparam logic [13:0] MAX_PAYLOAD_STD = 14'h05DC;
   localparam logic [13:0] MAX_PAYLOAD_JMB = 14'h2580;
   localparam logic [10:0] MAX_VLAN_FRAME  = 11'h5F2;
   localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY_R      = 32'hEDB88320;
   localparam logic [15:0] QUANTA_ZERO     = 16'h0000;

   typedef enum logic [3:0] {
      EFP_IDLE  = 4'b0000,
      EFP_PRE   = 4'b0001,
      EFP_SFD   = 4'b0010,
      EFP_DA    = 4'b0011,
      EFP_SA    = 4'b0100,
      EFP_VLAN  = 4'b0101,
      EFP_LT    = 4'b0110,
      EFP_PAYLD = 4'b0111,
      EFP_PAD   = 4'b1000,
      EFP_FCS   = 4'b1001
   } efp_state_e;

   typedef enum logic [1:0] {
      EFP_K_DATA  = 2'b00,
      EFP_K_XOFF  = 2'b01,
      EFP_K_XON   = 2'b10
   } efp_kind_e;

   typedef struct packed {
      logic [47:0] dst_addr;
      logic [47:0] src_addr;
      logic [15:0] len_type;
      logic [1:0]  vlan_count;
      logic [31:0] vlan_tags;
      logic        jumbo_en;
   } efp_hdr_s;

   typedef struct packed {
      logic [7:0] data;
      logic       en;
   } efp_tx_s;
endpackage
`default_nettype wire

// [efp_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module efp_chk (
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              fc_enable,
   input wire logic              xoff_pin,
   input wire logic              xon_pin,
   input wire logic              xoff_req_bit,
   input wire logic              xon_req_bit,
   input wire logic              remote_paused,
   input wire logic              tx_start,
   input wire logic              tx_data_ready,
   input wire logic              tx_busy,
   input wire logic              tx_len_error,
   input wire efp_pkg::efp_tx_s  mii_tx
);
   // ****************
   // Frame checks
   // ****************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic [11:0] len_q;
   logic [11:0] len_d;
   always_comb len_d = mii_tx.en ? len_q + 12'h001 : 12'h000;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) len_q <= 12'h000;
      else len_q <= len_d;
   end
   a_pre_sfd: assert property ($rose(mii_tx.en) |-> (mii_tx.data == 8'h55)[*7] ##1 (mii_tx.data == 8'hD5))
      else $error("preamble or delimiter wrong");
   a_len_min: assert property ($fell(mii_tx.en) |-> len_q >= 12'h048)
      else $error("frame too short");
   a_xoff_go: assert property ($rose(xoff_pin) && fc_enable && !xon_pin && !xon_req_bit && !tx_busy && !mii_tx.en
      && !tx_start && !$past(tx_start) |-> ##[1:4] mii_tx.en)
      else $error("xoff pin gave no frame");
   a_xon_go: assert property ($rose(xon_req_bit) && fc_enable && !xoff_pin && !xoff_req_bit && !tx_busy
      && !mii_tx.en && !tx_start && !$past(tx_start) |-> ##[1:4] mii_tx.en)
      else $error("xon bit gave no frame");
   a_fc_quiet: assert property ((!fc_enable && !tx_start && !tx_busy && !mii_tx.en)[*3] |=> !mii_tx.en)
      else $error("frame without request");
   a_pause_hold: assert property ((remote_paused && !fc_enable && !tx_busy && !mii_tx.en)[*3] |=> !mii_tx.en)
      else $error("data sent to paused station");
   a_ready_byte: assert property (tx_data_ready |=> mii_tx.en)
      else $error("no byte after ready");
   a_ready_busy: assert property (tx_data_ready |-> tx_busy)
      else $error("ready outside frame");
   cover property ($rose(mii_tx.en));
   cover property ($fell(mii_tx.en) && len_q > 12'h048);
   cover property ($rose(tx_len_error));
endmodule
bind efp_ethernet_frame_and_pause_generation efp_chk efp_chk_i (.ref_clk, .arst_n, .fc_enable, .xoff_pin, .xon_pin,
   .xoff_req_bit, .xon_req_bit, .remote_paused, .tx_start, .tx_data_ready, .tx_busy, .tx_len_error, .mii_tx);
`default_nettype wire

// [efp_remote.sv]
`timescale 1ns/1ps
`default_nettype none
module efp_remote (
   input wire logic             ref_clk,
   input wire efp_pkg::efp_tx_s mii_tx,
   output int                   n_frames,
   output logic                 fcs_ok
);
   // ****************
   // Receiving station
   // ****************
   logic [7:0]  cur[$];
   logic [7:0]  frame[$];
   logic [31:0] crc;
   initial begin
      n_frames = 0;
      fcs_ok = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (mii_tx.en) begin
         cur.push_back(mii_tx.data);
      end else if (cur.size() > 0) begin
         frame = cur;
         cur = {};
         crc = 32'hFFFFFFFF;
         for (int k = 8; k < frame.size(); k++) begin
            crc = crc ^ {24'h000000, frame[k]};
            for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ 32'hEDB88320 : crc >> 1;
         end
         fcs_ok = (crc == 32'hDEBB20E3);
         n_frames++;
      end
   end
endmodule
`default_nettype wire

// [tb_efp_ethernet_frame_and_pause_generation.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_efp_ethernet_frame_and_pause_generation;
   // ****************
   // Bench
   // ****************
   localparam logic [47:0] DA = 48'h0A0B0C0D0E0F;
   localparam logic [47:0] SA = 48'h112233445566;
   logic ref_clk = 1'b0, arst_n = 1'b0, fc_enable = 1'b0, rx_fifo_at_threshold = 1'b0, tx_last = 1'b0;
   logic xoff_req_bit = 1'b0, xon_req_bit = 1'b0, xoff_pin = 1'b0, xon_pin = 1'b0, remote_paused = 1'b0;
   logic tx_start = 1'b0, tx_data_ready, tx_busy, tx_len_error, is_ethertype, fcs_ok;
   logic [15:0] pause_quanta = 16'hA55A;
   logic [47:0] station_addr = 48'h0C0C0C0C0C0C, pause_dst_addr = 48'h0A1B2C3D4E5F;
   logic [7:0]  tx_data = 8'h00;
   efp_pkg::efp_hdr_s tx_hdr = '0;
   efp_pkg::efp_tx_s  mii_tx;
   int num_errors = 0, n_tests = 0, n_frames;
   efp_ethernet_frame_and_pause_generation efp_ethernet_frame_and_pause_generation_i (.ref_clk, .arst_n, .fc_enable,
      .rx_fifo_at_threshold, .xoff_req_bit, .xon_req_bit, .xoff_pin, .xon_pin, .pause_quanta, .station_addr,
      .pause_dst_addr, .remote_paused, .tx_start, .tx_hdr, .tx_data, .tx_last, .tx_data_ready, .tx_busy,
      .tx_len_error, .is_ethertype, .mii_tx);
   efp_remote efp_remote_i (.ref_clk(ref_clk), .mii_tx(mii_tx), .n_frames(n_frames), .fcs_ok(fcs_ok));
   always #50 ref_clk = ~ref_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e) begin
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wait_frm(input int n0);
      int i;
      i = 0;
      while (n_frames == n0 && i < 3000) begin
         tick(1);
         i++;
      end
      if (n_frames == n0) begin
         chk("frame_arrival", 48'h1, 48'h0);
         wrap_up();
      end
   endtask
   task automatic fld(input string nm, input int at, input int nb, input logic [47:0] e, input bit lsb);
      logic [47:0] g;
      g = '0;
      for (int k = 0; k < nb; k++) begin
         if (lsb) g[8*k+:8] = efp_remote_i.frame[at+k];
         else g = {g[39:0], efp_remote_i.frame[at+k]};
      end
      chk(nm, e, g);
   endtask
   task automatic head(input logic [47:0] da, input logic [47:0] sa, input int len);
      fld("preamble", 0, 6, 48'h555555555555, 0);
      fld("pre_sfd", 6, 2, 48'h55D5, 0);
      fld("dst_addr", 8, 6, da, 1);
      fld("src_addr", 14, 6, sa, 1);
      chk("frame_len", 48'(len), 48'(efp_remote_i.frame.size()));
      chk("fcs_ok", 48'h1, {47'h0, fcs_ok});
   endtask
   task automatic send(input logic [1:0] v, input logic [15:0] lt, input int n, input bit jmb = 1'b0);
      int i, n0;
      n0 = n_frames;
      tx_hdr = '{dst_addr: DA, src_addr: SA, len_type: lt, vlan_count: v, vlan_tags: 32'h12345678, jumbo_en: jmb};
      tx_start = 1'b1;
      i = 0;
      while (tx_data_ready !== 1'b1 && i < 200) begin
         tick(1);
         i++;
      end
      chk("data_ready", 48'h1, {47'h0, tx_data_ready});
      chk("busy_frame", 48'h1, {47'h0, tx_busy});
      tx_start = 1'b0;
      for (i = 0; i < n; i++) begin
         tx_data = i[7:0];
         tx_last = (i == n - 1);
         tick(1);
      end
      tx_last = 1'b0;
      wait_frm(n0);
      head(DA, SA, 26 + ((4 * v + n) > 46 ? 4 * v + n : 46));
   endtask
   task automatic t_frame(input logic [1:0] v, input logic [15:0] lt, input int n);
      send(v, lt, n);
      if (v > 0) fld("vlan_tag1", 20, 4, 48'h81001234, 0);
      if (v > 1) fld("vlan_tag2", 24, 4, 48'h81005678, 0);
      fld("len_type", 20 + 4 * v, 2, lt, 0);
      if (n > 1) fld("payload", 22 + 4 * v, 2, 48'h0001, 0);
      chk("is_ethertype", {47'h0, lt >= 16'h0600}, {47'h0, is_ethertype});
      chk("len_error", 48'h0, {47'h0, tx_len_error});
      chk("busy_idle", 48'h0, {47'h0, tx_busy});
      $display("test frame vlan %0d done", v);
   endtask
   task automatic t_paused;
      int n0;
      n0 = n_frames;
      remote_paused = 1'b1;
      tx_start = 1'b1;
      tick(300);
      chk("paused_frames", 48'(n0), 48'(n_frames));
      remote_paused = 1'b0;
      t_frame(2'h0, 16'h0600, 1);
      $display("test paused done");
   endtask
   task automatic t_lenerr;
      send(2'h0, 16'h05DD, 1501);
      chk("len_error", 48'h1, {47'h0, tx_len_error});
      send(2'h0, 16'h05DD, 1501, 1'b1);
      chk("jumbo_len_error", 48'h0, {47'h0, tx_len_error});
      $display("test length error done");
   endtask
   task automatic pchk(input logic [15:0] q);
      head(pause_dst_addr, station_addr, 72);
      fld("type_opcode", 20, 4, 48'h88080001, 0);
      fld("quanta", 24, 2, q, 0);
      fld("pad_head", 26, 6, 48'h0, 0);
      fld("pad_tail", 62, 6, 48'h0, 0);
   endtask
   task automatic t_pause(input bit xon);
      int n0;
      n0 = n_frames;
      if (xon) xon_req_bit = 1'b1;
      else xoff_pin = 1'b1;
      wait_frm(n0);
      pchk(xon ? 16'h0000 : pause_quanta);
      wait_frm(n0 + 1);
      pchk(xon ? 16'h0000 : pause_quanta);
      xon_req_bit = 1'b0;
      xoff_pin = 1'b0;
      tick(150);
      n0 = n_frames;
      tick(150);
      chk("frames_after_clear", 48'(n0), 48'(n_frames));
      $display("test pause %0d done", xon);
   endtask
   task automatic t_thresh;
      int n0;
      n0 = n_frames;
      rx_fifo_at_threshold = 1'b1;
      wait_frm(n0);
      pchk(pause_quanta);
      tick(300);
      chk("threshold_frames", 48'(n0 + 1), 48'(n_frames));
      rx_fifo_at_threshold = 1'b0;
      $display("test threshold done");
   endtask
   task automatic t_quiet;
      int n0;
      n0 = n_frames;
      xoff_pin = 1'b1;
      xon_pin = 1'b1;
      tick(300);
      chk("both_frames", 48'(n0), 48'(n_frames));
      xon_pin = 1'b0;
      fc_enable = 1'b0;
      tick(300);
      chk("disabled_frames", 48'(n0), 48'(n_frames));
      xoff_pin = 1'b0;
      $display("test quiet done");
   endtask
   initial begin
      tick(5);
      arst_n = 1'b1;
      tick(1);
      t_frame(2'h0, 16'h0005, 5);
      t_frame(2'h1, 16'h0800, 50);
      t_frame(2'h2, 16'h05FF, 38);
      t_paused();
      t_lenerr();
      fc_enable = 1'b1;
      t_pause(1'b0);
      t_pause(1'b1);
      t_thresh();
      t_quiet();
      wrap_up();
   end
endmodule
`default_nettype wire
